// *** core/nacvs_pkg.sv ***
// Purpose: Shared constants and types for the address change and volume select logic.
// Assumes: 25 MHz clock; two LUNs per target; one byte per link strobe.
// Notes: Least times round up to whole clock cycles.
package nacvs_pkg;
  localparam int CLK_MHZ = 25;
  localparam int T_CCS_NS = 300;
  localparam int T_CEH_NS = 20;
  localparam int T_VDLY_NS = 50;
  localparam int T_CEVDLY_NS = 50;
  localparam int CCS_CYC = (T_CCS_NS * CLK_MHZ + 999) / 1000;
  localparam int CEH_CYC = (T_CEH_NS * CLK_MHZ + 999) / 1000;
  localparam int VDLY_CYC = (T_VDLY_NS * CLK_MHZ + 999) / 1000;
  localparam int CEVDLY_CYC = (T_CEVDLY_NS * CLK_MHZ + 999) / 1000;

  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_READ_GO = 8'h30;
  localparam logic [7:0] OP_JOINT = 8'h05;
  localparam logic [7:0] OP_COL_GO = 8'he0;
  localparam logic [7:0] OP_ENH_RD = 8'h06;
  localparam logic [7:0] OP_PROG = 8'h80;
  localparam logic [7:0] OP_CHG_WR = 8'h85;
  localparam logic [7:0] OP_PROG_GO = 8'h10;
  localparam logic [7:0] OP_STAT_ENH = 8'h78;
  localparam logic [7:0] OP_RESET = 8'hff;
  localparam logic [7:0] OP_VOL_SEL = 8'he1;

  localparam int LUN_N = 2;
  localparam int LUN_BIT = 23;
  localparam int PLANE_BIT = 6;
  localparam logic [LUN_N-1:0] LUN_ONE = 2'h1;
  localparam int VOL_W = 4;
  localparam logic [3:0] VOL_RSVD = 4'h0;
  localparam logic [2:0] NONE_N = 3'h0;
  localparam logic [2:0] VOL_N = 3'h1;
  localparam logic [2:0] COL_N = 3'h2;
  localparam logic [2:0] ROW_N = 3'h3;
  localparam logic [2:0] FULL_N = 3'h5;
  localparam logic [1:0] SRC_FULL = 2'h0;
  localparam logic [1:0] SRC_COL = 2'h1;
  localparam logic [1:0] SRC_ROW = 2'h2;
  localparam logic [7:0] RD_TMO = 8'h03;

  typedef enum logic [3:0] {
    H_READ, H_ENH, H_JOINT, H_WCOL, H_WROW, H_PROG, H_PGO,
    H_WDATA, H_RDATA, H_VOL, H_RESET
  } nacvs_op_t;

  typedef enum logic [2:0] {
    VS_SEL = 3'b001,
    VS_DESEL = 3'b010,
    VS_SNIFF = 3'b100
  } nacvs_vol_t;
endpackage : nacvs_pkg

// *** core/nacvs_link_if.sv ***
// Purpose: Link between the host controller and the target, one strobe per cycle.
// Assumes: Single clock; host owns chip enable and the latch strobes.
// Notes: Data from the target is valid in the cycle its enable is high.
`timescale 1ns/1ps
interface nacvs_link_if (
  input wire logic clk,
  input wire logic rst_b
);
  logic ce_b;
  logic cle;
  logic ale;
  logic we;
  logic re;
  logic [7:0] dq_h;
  logic [7:0] dq_d;
  logic dq_d_oe;

  modport host (
    output ce_b,
    output cle,
    output ale,
    output we,
    output re,
    output dq_h,
    input dq_d,
    input dq_d_oe
  );

  modport target (
    input ce_b,
    input cle,
    input ale,
    input we,
    input re,
    input dq_h,
    output dq_d,
    output dq_d_oe
  );
endinterface : nacvs_link_if

// *** core/nacvs_addr_asm.sv ***
// Purpose: Shadow store for address bytes, least significant byte first.
// Assumes: clr and ale never arrive in the same cycle.
// Notes: Bytes past the fifth are dropped.
`timescale 1ns/1ps
module nacvs_addr_asm (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic ale,
  input wire logic [7:0] dq,
  output logic [39:0] bytes,
  output logic [2:0] cnt
);
  typedef struct packed {
    logic [39:0] sh;
    logic [2:0] n;
  } nacvs_asm_t;

  nacvs_asm_t q;
  nacvs_asm_t next_q;

  always_comb
  begin
    next_q = q;
    if (clr)
      next_q.n = nacvs_pkg::NONE_N;
    else if (ale && (q.n < nacvs_pkg::FULL_N))
    begin
      next_q.sh[{q.n, 3'h0} +: 8] = dq;
      next_q.n = q.n + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= next_q;
  end

  assign bytes = q.sh;
  assign cnt = q.n;
endmodule : nacvs_addr_asm

// *** core/nacvs_target.sv ***
// Purpose: Target end: address change commands and volume select.
// Assumes: Link strobes are one cycle wide and synchronous to clk.
// Notes: Page memory sits outside; this end only steers its pointers.
// How it works
// - Enhanced change loads LUN, plane, column.
// - Host uses enhanced change only if supported.
// - No enhanced change after target-level commands.
// - Idle unaddressed LUNs drop their output drivers.
// - Busy unaddressed LUNs: host sends status enhanced.
// - Joint variant ignores first column address.
// - Address bytes travel least significant first.
// - Write column change redirects later write data.
// - Host waits setup time before write data.
// - Row change retargets block, page, column.
// - Host keeps LUN and plane in row change.
// - Volume select accepted in any LUN state.
// - Volume select first after long chip-enable high.
// - Host sends volume select at single rate.
// - Mismatched volume deselects the target.
// - Terminator LUN of selected volume sniffs.
// - Unknown volume leaves every target deselected.
// - Late volume select keeps previous state.
// - Volume address survives reset commands.
// - Host waits select delay before next command.
// - Host holds chip enable low after select.
// - Volume in low nibble, upper nibble zero.
`timescale 1ns/1ps
module nacvs_target (
  input wire logic clk,
  input wire logic rst_b,
  nacvs_link_if.target link,
  input wire logic [3:0] my_volume,
  input wire logic [15:0] term_mask,
  input wire logic [nacvs_pkg::LUN_N-1:0] lun_ready,
  input wire logic [7:0] page_rd_data,
  output logic selected,
  output logic sniff,
  output logic [3:0] cur_volume,
  output logic [nacvs_pkg::LUN_N-1:0] lun_drv,
  output logic rd_lun,
  output logic [23:0] rd_row,
  output logic [15:0] rd_col,
  output logic read_go,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic [23:0] wr_row,
  output logic [15:0] wr_col,
  output logic prog_go
);
  typedef enum logic [8:0] {
    C_IDLE = 9'h001,
    C_RDA = 9'h002,
    C_JCOL = 9'h004,
    C_ENH = 9'h008,
    C_STAT = 9'h010,
    C_PRA = 9'h020,
    C_PGM = 9'h040,
    C_CHG = 9'h080,
    C_VOL = 9'h100
  } nacvs_cst_t;

  typedef struct packed {
    nacvs_pkg::nacvs_vol_t vs;
    logic [3:0] vol;
    logic ce_q;
    logic first;
    nacvs_cst_t c;
    logic [23:0] jrow;
    logic [nacvs_pkg::LUN_N-1:0] drv;
    logic rlun;
    logic [23:0] rrow;
    logic [15:0] rcol;
    logic rgo;
    logic [7:0] dqd;
    logic oe;
    logic wstb;
    logic [7:0] wdat;
    logic [23:0] wrow;
    logic [15:0] wptr;
    logic [15:0] wcol;
    logic pgo;
  } nacvs_tgt_t;

  nacvs_tgt_t q;
  nacvs_tgt_t next_q;
  logic aclr;
  logic fall;
  logic act;
  logic [3:0] vnum;
  logic [39:0] ab;
  logic [2:0] acnt;
  logic [15:0] acol;
  logic [23:0] arow;
  logic [nacvs_pkg::LUN_N-1:0] keep;

  nacvs_addr_asm i_nacvs_addr_asm (
    .clk(clk),
    .rst_b(rst_b),
    .clr(aclr),
    .ale(link.ale & ~link.ce_b),
    .dq(link.dq_h),
    .bytes(ab),
    .cnt(acnt)
  );

  assign acol = ab[15:0];
  assign arow = ab[39:16];

  // A busy LUN cannot be told to let go of the bus until status enhanced
  for (genvar i = 0; i < nacvs_pkg::LUN_N; i++)
  begin : g_keep
    assign keep[i] = q.drv[i] & ~lun_ready[i];
  end

  always_comb
  begin
    next_q = q;
    aclr = 1'b0;
    vnum = link.dq_h[nacvs_pkg::VOL_W-1:0];
    fall = q.ce_q & ~link.ce_b;
    act = ~link.ce_b & (q.vs == nacvs_pkg::VS_SEL);
    next_q.rgo = 1'b0;
    next_q.oe = 1'b0;
    next_q.wstb = 1'b0;
    next_q.pgo = 1'b0;
    next_q.ce_q = link.ce_b;
    if (fall)
      next_q.first = 1'b1;
    if (~link.ce_b & link.cle)
      next_q.first = 1'b0;
    if (~link.ce_b & link.ale & (q.c == C_VOL))
    begin
      next_q.vol = vnum;
      next_q.c = C_IDLE;
      if (vnum == my_volume)
        next_q.vs = nacvs_pkg::VS_SEL;
      else if (term_mask[vnum])
        next_q.vs = nacvs_pkg::VS_SNIFF;
      else
        next_q.vs = nacvs_pkg::VS_DESEL;
    end
    else if (~link.ce_b & link.cle & (link.dq_h == nacvs_pkg::OP_VOL_SEL))
    begin
      // Not first after the chip-enable fall: state stays as it was
      if (q.first | fall)
        next_q.c = C_VOL;
    end
    else if (act)
    begin
      // Shadowed bytes only take effect once the address phase is over
      if (((q.c == C_PRA) || (q.c == C_CHG)) & (link.cle | link.we | link.re))
      begin
        next_q.c = C_PGM;
        if (acnt == nacvs_pkg::FULL_N)
        begin
          next_q.wrow = arow;
          next_q.wptr = acol;
        end
        else if (acnt == nacvs_pkg::COL_N)
          next_q.wptr = acol;
      end
      if ((q.c == C_STAT) && (acnt == nacvs_pkg::ROW_N))
      begin
        // Status enhanced carries the row alone, so its top byte holds the LUN bit
        next_q.drv = nacvs_pkg::LUN_ONE << ab[nacvs_pkg::LUN_BIT];
        next_q.c = C_IDLE;
      end
      if (link.cle)
      begin
        case (link.dq_h)
          nacvs_pkg::OP_RESET:
          begin
            // Volume state and address are left untouched
            next_q.c = C_IDLE;
            next_q.rcol = 16'h0000;
            next_q.wptr = 16'h0000;
          end
          nacvs_pkg::OP_READ:
          begin
            aclr = 1'b1;
            next_q.c = C_RDA;
          end
          nacvs_pkg::OP_READ_GO:
          begin
            next_q.c = C_IDLE;
            if (q.c == C_RDA)
            begin
              next_q.rrow = arow;
              next_q.rcol = acol;
              next_q.rlun = arow[nacvs_pkg::LUN_BIT];
              next_q.drv = nacvs_pkg::LUN_ONE << arow[nacvs_pkg::LUN_BIT];
              next_q.rgo = 1'b1;
            end
          end
          nacvs_pkg::OP_JOINT:
          begin
            next_q.c = C_IDLE;
            if (q.c == C_RDA)
            begin
              next_q.jrow = arow;
              aclr = 1'b1;
              next_q.c = C_JCOL;
            end
          end
          nacvs_pkg::OP_ENH_RD:
          begin
            aclr = 1'b1;
            next_q.c = C_ENH;
          end
          nacvs_pkg::OP_COL_GO:
          begin
            next_q.c = C_IDLE;
            if (q.c == C_ENH)
            begin
              next_q.rrow = arow;
              next_q.rcol = acol;
              next_q.rlun = arow[nacvs_pkg::LUN_BIT];
              next_q.drv = keep | (nacvs_pkg::LUN_ONE << arow[nacvs_pkg::LUN_BIT]);
            end
            else if (q.c == C_JCOL)
            begin
              next_q.rrow = q.jrow;
              next_q.rcol = acol;
              next_q.rlun = q.jrow[nacvs_pkg::LUN_BIT];
              next_q.drv = keep | (nacvs_pkg::LUN_ONE << q.jrow[nacvs_pkg::LUN_BIT]);
            end
          end
          nacvs_pkg::OP_STAT_ENH:
          begin
            aclr = 1'b1;
            next_q.c = C_STAT;
          end
          nacvs_pkg::OP_PROG:
          begin
            aclr = 1'b1;
            next_q.c = C_PRA;
          end
          nacvs_pkg::OP_CHG_WR:
          begin
            if (next_q.c == C_PGM)
            begin
              aclr = 1'b1;
              next_q.c = C_CHG;
            end
          end
          nacvs_pkg::OP_PROG_GO:
          begin
            next_q.pgo = (next_q.c == C_PGM);
            next_q.c = C_IDLE;
          end
          default:
            next_q.c = C_IDLE;
        endcase
      end
      else if (link.we && (next_q.c == C_PGM))
      begin
        next_q.wstb = 1'b1;
        next_q.wdat = link.dq_h;
        next_q.wcol = next_q.wptr;
        next_q.wptr = next_q.wptr + 16'h0001;
      end
      else if (link.re && q.drv[q.rlun])
      begin
        next_q.oe = 1'b1;
        next_q.dqd = page_rd_data;
        next_q.rcol = q.rcol + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.vs <= nacvs_pkg::VS_SEL;
      q.c <= C_IDLE;
      q.ce_q <= 1'b1;
    end
    else
      q <= next_q;
  end

  assign link.dq_d = q.dqd;
  assign link.dq_d_oe = q.oe;
  assign selected = q.vs[0];
  assign sniff = q.vs[2];
  assign cur_volume = q.vol;
  assign lun_drv = q.drv;
  assign rd_lun = q.rlun;
  assign rd_row = q.rrow;
  assign rd_col = q.rcol;
  assign read_go = q.rgo;
  assign wr_stb = q.wstb;
  assign wr_data = q.wdat;
  assign wr_row = q.wrow;
  assign wr_col = q.wcol;
  assign prog_go = q.pgo;
endmodule : nacvs_target

// *** core/nacvs_host.sv ***
// Purpose: Host end: turns requests into command, address and data strobes.
// Assumes: Link runs at single rate only, so volume select needs no mode change.
// Notes: Enhanced column change is always followed by status enhanced.
`timescale 1ns/1ps
module nacvs_host (
  input wire logic clk,
  input wire logic rst_b,
  nacvs_link_if.host link,
  input wire logic enh_supported,
  input wire logic req_valid,
  input wire nacvs_pkg::nacvs_op_t req_op,
  input wire logic [15:0] req_col,
  input wire logic [23:0] req_row,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [7:0] rsp_data
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_GAP = 7'h02,
    S_CEH = 7'h04,
    S_CMD = 7'h08,
    S_ADR = 7'h10,
    S_RD = 7'h20,
    S_WAIT = 7'h40
  } nacvs_hst_t;

  typedef struct packed {
    nacvs_hst_t st;
    logic ce_b;
    logic cle;
    logic ale;
    logic we;
    logic re;
    logic [7:0] dq;
    logic [3:0][7:0] cmds;
    logic [3:0][2:0] nad;
    logic [3:0][1:0] src;
    logic [1:0] ph;
    logic [1:0] last;
    logic [2:0] n;
    logic [39:0] sh;
    logic [15:0] col;
    logic [23:0] row;
    logic [23:0] prow;
    logic [7:0] wt;
    logic [7:0] post;
    logic [7:0] age;
    logic isvol;
    logic tgt;
    logic rdy;
    logic rv;
    logic err;
    logic [7:0] rd;
  } nacvs_h_t;

  nacvs_h_t q;
  nacvs_h_t next_q;
  logic done;

  always_comb
  begin
    next_q = q;
    done = 1'b0;
    next_q.cle = 1'b0;
    next_q.ale = 1'b0;
    next_q.we = 1'b0;
    next_q.re = 1'b0;
    next_q.rv = 1'b0;
    next_q.err = 1'b0;
    if (q.age != 8'hff)
      next_q.age = q.age + 8'h01;
    unique case (q.st)
      S_IDLE:
      begin
        if (req_valid && q.rdy)
        begin
          next_q.rdy = 1'b0;
          next_q.col = req_col;
          next_q.row = req_row;
          next_q.ph = 2'h0;
          next_q.last = 2'h0;
          next_q.post = 8'h00;
          next_q.isvol = 1'b0;
          next_q.tgt = 1'b0;
          next_q.st = S_CMD;
          next_q.src = {4{nacvs_pkg::SRC_FULL}};
          next_q.nad = {4{nacvs_pkg::NONE_N}};
          unique case (req_op)
            nacvs_pkg::H_READ:
            begin
              next_q.cmds = {16'h0000, nacvs_pkg::OP_READ_GO, nacvs_pkg::OP_READ};
              next_q.nad[0] = nacvs_pkg::FULL_N;
              next_q.last = 2'h1;
            end
            nacvs_pkg::H_ENH, nacvs_pkg::H_JOINT:
            begin
              if (!enh_supported || q.tgt)
              begin
                next_q.st = S_IDLE;
                next_q.rdy = 1'b1;
                next_q.rv = 1'b1;
                next_q.err = 1'b1;
              end
              else if (req_op == nacvs_pkg::H_ENH)
              begin
                next_q.cmds = {8'h00, nacvs_pkg::OP_STAT_ENH, nacvs_pkg::OP_COL_GO,
                  nacvs_pkg::OP_ENH_RD};
                next_q.nad = {nacvs_pkg::NONE_N, nacvs_pkg::ROW_N, nacvs_pkg::NONE_N,
                  nacvs_pkg::FULL_N};
                next_q.src[2] = nacvs_pkg::SRC_ROW;
                next_q.last = 2'h2;
                next_q.post = 8'(nacvs_pkg::CCS_CYC);
              end
              else
              begin
                next_q.cmds = {nacvs_pkg::OP_STAT_ENH, nacvs_pkg::OP_COL_GO,
                  nacvs_pkg::OP_JOINT, nacvs_pkg::OP_READ};
                next_q.nad = {nacvs_pkg::ROW_N, nacvs_pkg::NONE_N, nacvs_pkg::COL_N,
                  nacvs_pkg::FULL_N};
                next_q.src[1] = nacvs_pkg::SRC_COL;
                next_q.src[3] = nacvs_pkg::SRC_ROW;
                next_q.last = 2'h3;
                next_q.post = 8'(nacvs_pkg::CCS_CYC);
              end
            end
            nacvs_pkg::H_WCOL, nacvs_pkg::H_WROW:
            begin
              next_q.cmds = {24'h000000, nacvs_pkg::OP_CHG_WR};
              next_q.post = 8'(nacvs_pkg::CCS_CYC);
              next_q.nad[0] = nacvs_pkg::COL_N;
              next_q.src[0] = nacvs_pkg::SRC_COL;
              if (req_op == nacvs_pkg::H_WROW)
              begin
                next_q.nad[0] = nacvs_pkg::FULL_N;
                next_q.src[0] = nacvs_pkg::SRC_FULL;
                next_q.row[nacvs_pkg::LUN_BIT] = q.prow[nacvs_pkg::LUN_BIT];
                next_q.row[nacvs_pkg::PLANE_BIT] = q.prow[nacvs_pkg::PLANE_BIT];
              end
            end
            nacvs_pkg::H_PROG:
            begin
              next_q.cmds = {24'h000000, nacvs_pkg::OP_PROG};
              next_q.nad[0] = nacvs_pkg::FULL_N;
              next_q.prow = req_row;
            end
            nacvs_pkg::H_PGO:
              next_q.cmds = {24'h000000, nacvs_pkg::OP_PROG_GO};
            nacvs_pkg::H_VOL:
            begin
              next_q.cmds = {24'h000000, nacvs_pkg::OP_VOL_SEL};
              next_q.nad[0] = nacvs_pkg::VOL_N;
              next_q.src[0] = nacvs_pkg::SRC_COL;
              next_q.col = {8'h00, nacvs_pkg::VOL_RSVD, req_data[3:0]};
              next_q.post = 8'(nacvs_pkg::VDLY_CYC);
              next_q.isvol = 1'b1;
              next_q.tgt = 1'b1;
              next_q.st = S_GAP;
            end
            nacvs_pkg::H_RESET:
            begin
              next_q.cmds = {24'h000000, nacvs_pkg::OP_RESET};
              next_q.tgt = 1'b1;
            end
            nacvs_pkg::H_WDATA:
            begin
              next_q.we = 1'b1;
              next_q.dq = req_data;
              next_q.wt = 8'h00;
              next_q.st = S_WAIT;
            end
            nacvs_pkg::H_RDATA:
            begin
              next_q.re = 1'b1;
              next_q.wt = nacvs_pkg::RD_TMO;
              next_q.st = S_RD;
            end
          endcase
        end
      end
      S_GAP:
      begin
        // Raising chip enable too early could abort the previous selection
        if (q.age >= 8'(nacvs_pkg::CEVDLY_CYC))
        begin
          next_q.ce_b = 1'b1;
          next_q.wt = 8'(nacvs_pkg::CEH_CYC);
          next_q.st = S_CEH;
        end
      end
      S_CEH:
      begin
        next_q.wt = q.wt - 8'h01;
        if (q.wt <= 8'h01)
        begin
          next_q.ce_b = 1'b0;
          next_q.st = S_CMD;
        end
      end
      S_CMD:
      begin
        next_q.cle = 1'b1;
        next_q.dq = q.cmds[q.ph];
        next_q.n = q.nad[q.ph];
        unique case (q.src[q.ph])
          nacvs_pkg::SRC_COL: next_q.sh = {24'h000000, q.col};
          nacvs_pkg::SRC_ROW: next_q.sh = {16'h0000, q.row};
          default: next_q.sh = {q.row, q.col};
        endcase
        if (q.nad[q.ph] != nacvs_pkg::NONE_N)
          next_q.st = S_ADR;
        else if (q.ph == q.last)
          done = 1'b1;
        else
          next_q.ph = q.ph + 2'h1;
      end
      S_ADR:
      begin
        next_q.ale = 1'b1;
        next_q.dq = q.sh[7:0];
        next_q.sh = {8'h00, q.sh[39:8]};
        next_q.n = q.n - 3'h1;
        if (q.n == 3'h1)
        begin
          if (q.ph == q.last)
            done = 1'b1;
          else
          begin
            next_q.ph = q.ph + 2'h1;
            next_q.st = S_CMD;
          end
        end
      end
      S_RD:
      begin
        next_q.wt = q.wt - 8'h01;
        if (link.dq_d_oe || (q.wt == 8'h00))
        begin
          next_q.rd = link.dq_d;
          next_q.err = ~link.dq_d_oe;
          next_q.rv = 1'b1;
          next_q.rdy = 1'b1;
          next_q.st = S_IDLE;
        end
      end
      S_WAIT:
      begin
        next_q.wt = q.wt - 8'h01;
        if (q.wt == 8'h00)
        begin
          next_q.rv = 1'b1;
          next_q.rdy = 1'b1;
          next_q.st = S_IDLE;
        end
      end
      default:
        next_q.st = S_IDLE;
    endcase
    if (done)
    begin
      next_q.wt = q.post;
      next_q.st = S_WAIT;
      if (q.isvol)
        next_q.age = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.rdy <= 1'b1;
      q.age <= 8'hff;
    end
    else
      q <= next_q;
  end

  assign link.ce_b = q.ce_b;
  assign link.cle = q.cle;
  assign link.ale = q.ale;
  assign link.we = q.we;
  assign link.re = q.re;
  assign link.dq_h = q.dq;
  assign req_ready = q.rdy;
  assign rsp_valid = q.rv;
  assign rsp_err = q.err;
  assign rsp_data = q.rd;
endmodule : nacvs_host

// *** verification/nacvs_props.sv ***
// Purpose: Link checks between host and target.
// Assumes: One clock; rst_b active low.
// Notes: Pointer effects are left to the bench.
`timescale 1ns/1ps
module nacvs_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce_b,
  input wire logic cle,
  input wire logic ale,
  input wire logic we,
  input wire logic re,
  input wire logic [7:0] dq_h,
  input wire logic dq_d_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_vol;
    cle && dq_h == 8'he1 ##1 ale;
  endsequence
  sequence s_col;
    cle && dq_h == 8'h85 ##1 ale ##1 ale;
  endsequence
  AST_VOL_RSVD: assert property (s_vol |-> dq_h[7:4] == 4'h0)
    else $error("volume high nibble");
  AST_VOL_FIRST: assert property (cle && dq_h == 8'he1 |-> !ce_b && $past(ce_b, 2))
    else $error("volume select not first");
  AST_VOL_CE: assert property (s_vol |=> !ce_b [*2])
    else $error("chip enable rose early");
  AST_VOL_DLY: assert property (s_vol |=> !cle [*2])
    else $error("command too early");
  AST_COL_ADDR: assert property (cle && dq_h == 8'h85 |=> ale ##1 ale)
    else $error("column bytes missing");
  AST_COL_SETUP: assert property (s_col |=> !we [*8])
    else $error("write data too early");
  AST_JOINT: assert property (cle && dq_h == 8'h05 ##1 ale [*2] |=> cle && dq_h == 8'he0)
    else $error("joint not closed");
  AST_ENH_STAT: assert property (cle && dq_h == 8'he0 |=> cle && dq_h == 8'h78)
    else $error("status enhanced missing");
  AST_OUT_RE: assert property (dq_d_oe |-> $past(re))
    else $error("data without read strobe");
endmodule : nacvs_props

// *** verification/test_nand_addr_change_volume_select.sv ***
// Purpose: Random host requests checked at both ends.
// Assumes: Target volume 5; the bench models page bytes.
// Notes: Fixed seed, so a failure repeats.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_nand_addr_change_volume_select;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic enh_supported = 1'b1;
  logic req_valid = 1'b0;
  nacvs_pkg::nacvs_op_t req_op = nacvs_pkg::H_READ;
  logic [15:0] req_col = 16'h0000;
  logic [23:0] req_row = 24'h000000;
  logic [7:0] req_data = 8'h00;
  logic [15:0] term_mask = 16'h0000;
  logic [1:0] lun_ready = 2'h3;
  logic [3:0] my_volume = 4'h5;
  logic req_ready, rsp_valid, rsp_err, selected, sniff, rd_lun, read_go, wr_stb, prog_go, err;
  logic [7:0] rsp_data, page_rd_data, wr_data, seen_data;
  logic [3:0] cur_volume, v;
  logic [1:0] lun_drv;
  logic [23:0] rd_row, wr_row, t;
  logic [15:0] rd_col, wr_col, seen_col;
  int fail_count = 0;
  int samples_checked = 0;
  int reads = 0;
  int progs = 0;
  int k;
  nacvs_link_if link (.clk, .rst_b);
  nacvs_host i_nacvs_host (.clk, .rst_b, .link(link.host), .enh_supported, .req_valid,
    .req_op, .req_col, .req_row, .req_data, .req_ready, .rsp_valid, .rsp_err, .rsp_data);
  nacvs_target i_nacvs_target (.clk, .rst_b, .link(link.target), .my_volume, .term_mask,
    .lun_ready, .page_rd_data, .selected, .sniff, .cur_volume, .lun_drv, .rd_lun, .rd_row,
    .rd_col, .read_go, .wr_stb, .wr_data, .wr_row, .wr_col, .prog_go);
  nacvs_props i_nacvs_props (.clk, .rst_b, .ce_b(link.ce_b), .cle(link.cle), .ale(link.ale),
    .we(link.we), .re(link.re), .dq_h(link.dq_h), .dq_d_oe(link.dq_d_oe));
  // Byte depends on LUN too, so a read from the wrong LUN shows up
  function automatic logic [7:0] page_byte(input logic lun, input logic [15:0] c);
    return c[7:0] ^ {lun, 7'h2a};
  endfunction : page_byte
  assign page_rd_data = page_byte(rd_lun, rd_col);
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (wr_stb)
    begin
      seen_col <= wr_col;
      seen_data <= wr_data;
    end
    reads <= reads + int'(read_go);
    progs <= progs + int'(prog_go);
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Two spare cycles let one-cycle target pulses reach the monitor
  task automatic do_req(input nacvs_pkg::nacvs_op_t op);
    int n;
    req_op = op;
    req_valid = 1'b1;
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1; n++)
    begin
      if (n == 60)
      begin
        fail_count++;
        give_verdict();
      end
      @(posedge clk);
      #2;
    end
    err = rsp_err;
    repeat (2) @(posedge clk);
    #2;
  endtask : do_req
  initial
  begin
    void'($urandom(32'h7102));
    repeat (6) @(posedge clk);
    #2;
    rst_b = 1'b1;
    do_req(nacvs_pkg::H_READ);
    for (int i = 0; i < 4; i++)
    begin
      req_col = 16'($urandom);
      req_row = 24'($urandom);
      lun_ready = 2'(i);
      do_req(i == 3 ? nacvs_pkg::H_JOINT : nacvs_pkg::H_ENH);
      `CHK("rd_col", req_col, rd_col)
      `CHK("rd_row", req_row, rd_row)
      `CHK("rd_lun", req_row[23], rd_lun)
      `CHK("lun_drv", 2'h1 << req_row[23], lun_drv)
      do_req(nacvs_pkg::H_RDATA);
      `CHK("rd_data", page_byte(req_row[23], req_col), rsp_data)
    end
    enh_supported = 1'b0;
    do_req(nacvs_pkg::H_ENH);
    `CHK("enh_off", 1'b1, err)
    `CHK("ready_after_refuse", 1'b1, req_ready)
    enh_supported = 1'b1;
    term_mask = (16'($urandom) | 16'h0001) & 16'hfffd;
    for (int i = 0; i < 6; i++)
    begin
      v = i < 2 ? 4'(i) : i % 3 == 2 ? 4'h5 : 4'($urandom);
      req_data = {4'($urandom), v};
      lun_ready = 2'($urandom);
      do_req(nacvs_pkg::H_VOL);
      `CHK("selected", v == 4'h5, selected)
      `CHK("sniff", v != 4'h5 && term_mask[v], sniff)
      `CHK("cur_volume", v, cur_volume)
      k = reads;
      do_req(nacvs_pkg::H_READ);
      `CHK("read_go", v == 4'h5, reads - k)
    end
    do_req(nacvs_pkg::H_RESET);
    `CHK("vol_kept", 4'h5, cur_volume)
    `CHK("sel_kept", 1'b1, selected)
    do_req(nacvs_pkg::H_ENH);
    `CHK("enh_after_reset", 1'b1, err)
    req_col = 16'($urandom);
    req_row = 24'($urandom);
    t = req_row;
    do_req(nacvs_pkg::H_PROG);
    for (int i = 0; i < 3; i++)
    begin
      if (i > 0)
      begin
        req_col = 16'($urandom);
        req_row = 24'($urandom);
        if (i == 2)
          t = {t[23], req_row[22:7], t[6], req_row[5:0]};
        do_req(i == 1 ? nacvs_pkg::H_WCOL : nacvs_pkg::H_WROW);
      end
      req_data = 8'($urandom);
      do_req(nacvs_pkg::H_WDATA);
      `CHK("wr_col", req_col, seen_col)
      `CHK("wr_data", req_data, seen_data)
      `CHK("wr_row", t, wr_row)
    end
    k = progs;
    do_req(nacvs_pkg::H_PGO);
    `CHK("prog_go", k + 1, progs)
    give_verdict();
  end
endmodule : test_nand_addr_change_volume_select
